// file: hw/cms_defines.vh
`ifndef CMS_DEFINES_VH
`define CMS_DEFINES_VH

// ****************************************************************
// Timing
// ****************************************************************
`define CMS_CLK_PERIOD_NS   8
`define CMS_POR_LONG_MS     100
`define CMS_POR_SHORT_MS    12
`define CMS_NS_PER_MS       1000000
`define CMS_POR_LONG_CYC    ((`CMS_POR_LONG_MS * `CMS_NS_PER_MS) / `CMS_CLK_PERIOD_NS)
`define CMS_POR_SHORT_CYC   ((`CMS_POR_SHORT_MS * `CMS_NS_PER_MS) / `CMS_CLK_PERIOD_NS)
`define CMS_CNT_W           24
`define CMS_INIT_CYC        24'h000010

// ****************************************************************
// Load schemes
// ****************************************************************
`define CMS_SCHEME_W        3
`define CMS_SCHEME_FPP      3'h0
`define CMS_SCHEME_SELF_SER 3'h1
`define CMS_SCHEME_HOST_SER 3'h2
`define CMS_SCHEME_ASYNC_PAR 3'h3
`define CMS_SCHEME_TAP      3'h4

// ****************************************************************
// Test port instruction and data path
// ****************************************************************
`define CMS_IR_W            10
`define CMS_IR_RECONFIG     10'h001
`define CMS_DATA_W          8
`define CMS_FIFO_DEPTH      16
`define CMS_FIFO_AW         4
`define CMS_KEY_W           128

`endif

// file: hw/cms_fifo.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Flop-based FIFO between load front end and frame writer
// ****************************************************************
module cms_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             mclk,
	input  wire             rst_b,
	input  wire             ce,
	input  wire             flush,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg  [AW-1:0]    wr_q;
	reg  [AW-1:0]    rd_q;
	reg  [AW:0]      cnt_q;
	wire             push;
	wire             pop;

	// Full and empty straight from the count
	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointers and count; flush drops stale data on restart
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else if (ce)
		begin
			if (flush)
			begin
				wr_q  <= {AW{1'b0}};
				rd_q  <= {AW{1'b0}};
				cnt_q <= {(AW+1){1'b0}};
			end
			else
			begin
				if (push)
					wr_q <= wr_q + 1'b1;
				if (pop)
					rd_q <= rd_q + 1'b1;
				if (push & ~pop)
					cnt_q <= cnt_q + 1'b1;
				else if (pop & ~push)
					cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	// Storage needs no reset
	always @(posedge mclk)
	begin
		if (ce & push)
			mem_q[wr_q] <= in_data;
	end
endmodule // cms_fifo

`default_nettype wire

// file: hw/cms_config_mode_sequencer.v
// How it works
// - delay 100 ms if select low, else 12 ms
// - pull-ups off when select high, configuring
// - I/O tri-stated through power-up and configuration
// - after load, init resets registers, enables I/O
// - user mode only after load and init
// - reconfig request reloads, reinitialises, resumes user
// - accept data via any of five schemes
// - expand compressed stream on the fly
// - host writes to virtual location as data
// - decrypt encrypted stream with AES before applying
// - test instruction 001 acts as reconfig pulse
// - chain enable out drives next device in
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.vh"

module cms_config_mode_sequencer #(
	parameter [`CMS_CNT_W-1:0] POR_LONG_CYC  = `CMS_POR_LONG_CYC,
	parameter [`CMS_CNT_W-1:0] POR_SHORT_CYC = `CMS_POR_SHORT_CYC
) (
	input  wire                     mclk,
	input  wire                     rst_b,
	input  wire                     ce,
	input  wire                     power_on_delay_select,
	input  wire                     pullup_disable_sel,
	input  wire                     reconfig_request_n,
	input  wire                     chain_load_enable_in_n,
	input  wire [`CMS_SCHEME_W-1:0] load_scheme,
	input  wire                     decompress_en,
	input  wire                     decrypt_en,
	input  wire [`CMS_KEY_W-1:0]    aes_key,
	input  wire [`CMS_DATA_W-1:0]   load_data,
	input  wire                     load_strobe,
	input  wire                     load_last,
	input  wire [`CMS_IR_W-1:0]     tap_instr,
	input  wire                     tap_update,
	input  wire                     host_wr,
	input  wire [`CMS_DATA_W-1:0]   host_wdata,
	output wire                     load_ready,
	output reg  [`CMS_DATA_W-1:0]   frame_data,
	output reg                      frame_write,
	output reg                      aes_start,
	output reg  [`CMS_DATA_W-1:0]   aes_byte,
	input  wire                     aes_done,
	input  wire [`CMS_DATA_W-1:0]   aes_plain,
	output reg                      io_hiz_n,
	output reg                      weak_pullup_en,
	output reg                      user_reset,
	output reg                      user_mode,
	output reg                      command_mode,
	output reg                      chain_load_enable_out_n
);
	// ****************************************************************
	// States
	// ****************************************************************
	localparam [4:0] ST_POR  = 5'h01;
	localparam [4:0] ST_WAIT = 5'h02;
	localparam [4:0] ST_LOAD = 5'h04;
	localparam [4:0] ST_INIT = 5'h08;
	localparam [4:0] ST_USER = 5'h10;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	reg  [1:0] sel_s_q;
	reg  [1:0] pu_s_q;
	reg  [1:0] rq_s_q;
	reg  [1:0] ce_s_q;
	reg        rq_prev_q;

	// Two flops on every pin before use
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pu_s_q    <= 2'h0;
			rq_s_q    <= 2'h3;
			ce_s_q    <= 2'h3;
			rq_prev_q <= 1'b1;
		end
		else if (ce)
		begin
			pu_s_q    <= {pu_s_q[0], pullup_disable_sel};
			rq_s_q    <= {rq_s_q[0], reconfig_request_n};
			ce_s_q    <= {ce_s_q[0], chain_load_enable_in_n};
			rq_prev_q <= rq_s_q[1];
		end
	end

	// Select pin keeps tracking in reset, so the one capture sees it settled
	always @(posedge mclk)
	begin
		if (ce)
			sel_s_q <= {sel_s_q[0], power_on_delay_select};
	end

	// Falling request pin or the test instruction starts a reload
	wire tap_reconfig = tap_update & (tap_instr == `CMS_IR_RECONFIG);
	wire reconfig_req = (rq_prev_q & ~rq_s_q[1]) | tap_reconfig;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	reg  [4:0]            st_q;
	reg  [4:0]            st_d;
	reg  [`CMS_CNT_W-1:0] cnt_q;
	reg  [`CMS_CNT_W-1:0] cnt_d;
	reg  [`CMS_CNT_W-1:0] por_len_q;
	reg                   last_seen_q;
	reg                   aes_busy_q;
	wire                  fifo_empty;

	// Next-state logic; a falling edge of the request pin or the test instruction restarts the load, holding the pin low does not
	always @*
	begin
		st_d  = st_q;
		cnt_d = cnt_q;
		case (st_q)
			ST_POR:
			begin
				// Delay length captured on entry, held for this power cycle
				st_d  = ST_WAIT;
				cnt_d = {`CMS_CNT_W{1'b0}};
			end
			ST_WAIT:
			begin
				if (cnt_q >= por_len_q - 1'b1)
					st_d = ST_LOAD;
				else
					cnt_d = cnt_q + 1'b1;
			end
			ST_LOAD:
			begin
				if (reconfig_req)
					st_d = ST_LOAD;
				else if (last_seen_q & fifo_empty & ~aes_busy_q)
				begin
					st_d  = ST_INIT;
					cnt_d = {`CMS_CNT_W{1'b0}};
				end
			end
			ST_INIT:
			begin
				if (reconfig_req)
					st_d = ST_LOAD;
				else if (cnt_q == `CMS_INIT_CYC)
					st_d = ST_USER;
				else
					cnt_d = cnt_q + 1'b1;
			end
			ST_USER:
			begin
				if (reconfig_req)
					st_d = ST_LOAD;
			end
			default:
				st_d = ST_POR;
		endcase
	end

	// State, counter and one-time capture of the delay select
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_q      <= ST_POR;
			cnt_q     <= {`CMS_CNT_W{1'b0}};
			por_len_q <= POR_LONG_CYC;
		end
		else if (ce)
		begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			if (st_q == ST_POR)
				por_len_q <= sel_s_q[1] ? POR_SHORT_CYC : POR_LONG_CYC;
		end
	end

	// ****************************************************************
	// Load front end
	// ****************************************************************
	wire                   in_loading = (st_q == ST_LOAD) & ~ce_s_q[1];
	wire                   scheme_ok  = (load_scheme <= `CMS_SCHEME_TAP);
	wire                   host_sel   = (load_scheme == `CMS_SCHEME_HOST_SER) |
	                                    (load_scheme == `CMS_SCHEME_ASYNC_PAR);
	wire [`CMS_DATA_W-1:0] src_data   = (host_sel & host_wr) ? host_wdata : load_data;
	wire                   src_valid  = in_loading & scheme_ok & ~last_seen_q &
	                                    (load_strobe | (host_sel & host_wr));
	wire                   fifo_ready;
	wire [`CMS_DATA_W-1:0] fifo_dout;
	wire                   fifo_valid;
	reg                    fifo_pop;
	reg  [`CMS_DATA_W-1:0] rle_byte_q;
	reg  [`CMS_DATA_W-1:0] rle_cnt_q;
	reg                    rle_hdr_q;

	assign load_ready = in_loading & scheme_ok & fifo_ready & ~last_seen_q;
	assign fifo_empty = ~fifo_valid & (rle_cnt_q == {`CMS_DATA_W{1'b0}});

	// Stream buffer; source stalls on load_ready when full
	cms_fifo #(
		.WIDTH (`CMS_DATA_W),
		.DEPTH (`CMS_FIFO_DEPTH),
		.AW    (`CMS_FIFO_AW)
	) u_fifo (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.ce        (ce),
		.flush     (reconfig_req),
		.in_data   (src_data),
		.in_valid  (src_valid & fifo_ready),
		.in_ready  (fifo_ready),
		.out_data  (fifo_dout),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// Pop only when the expander and cipher are idle
	always @*
	begin
		fifo_pop = fifo_valid & ~aes_busy_q & (rle_cnt_q == {`CMS_DATA_W{1'b0}});
	end

	// ****************************************************************
	// Frame writer: inline run expansion and cipher hand-off
	// ****************************************************************
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			last_seen_q <= 1'b0;
			aes_busy_q  <= 1'b0;
			aes_start   <= 1'b0;
			aes_byte    <= {`CMS_DATA_W{1'b0}};
			frame_data  <= {`CMS_DATA_W{1'b0}};
			frame_write <= 1'b0;
			rle_byte_q  <= {`CMS_DATA_W{1'b0}};
			rle_cnt_q   <= {`CMS_DATA_W{1'b0}};
			rle_hdr_q   <= 1'b0;
		end
		else if (ce)
		begin
			frame_write <= 1'b0;
			aes_start   <= 1'b0;
			if (reconfig_req)
			begin
				last_seen_q <= 1'b0;
				aes_busy_q  <= 1'b0;
				rle_cnt_q   <= {`CMS_DATA_W{1'b0}};
				rle_hdr_q   <= 1'b0;
			end
			else
			begin
				if (src_valid & fifo_ready & load_last)
					last_seen_q <= 1'b1;
				if (aes_busy_q & aes_done)
				begin
					// Plain text goes to the array only after decryption
					aes_busy_q  <= 1'b0;
					frame_data  <= aes_plain;
					frame_write <= 1'b1;
				end
				else if (rle_cnt_q != {`CMS_DATA_W{1'b0}})
				begin
					// Runs are replayed byte by byte, no second pass
					rle_cnt_q   <= rle_cnt_q - 1'b1;
					frame_data  <= rle_byte_q;
					frame_write <= 1'b1;
				end
				else if (fifo_pop & decrypt_en)
				begin
					aes_byte   <= fifo_dout;
					aes_start  <= 1'b1;
					aes_busy_q <= 1'b1;
				end
				else if (fifo_pop & decompress_en & ~rle_hdr_q)
				begin
					// Header byte holds the run length
					rle_hdr_q <= 1'b1;
					rle_cnt_q <= {`CMS_DATA_W{1'b0}};
					rle_byte_q <= fifo_dout;
				end
				else if (fifo_pop & decompress_en)
				begin
					rle_hdr_q  <= 1'b0;
					rle_cnt_q  <= rle_byte_q;
					rle_byte_q <= fifo_dout;
				end
				else if (fifo_pop)
				begin
					frame_data  <= fifo_dout;
					frame_write <= 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Pin control outputs
	// ****************************************************************
	// Registered so pins never glitch on state decode
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			io_hiz_n                <= 1'b0;
			weak_pullup_en          <= 1'b0;
			user_reset              <= 1'b1;
			user_mode               <= 1'b0;
			command_mode            <= 1'b1;
			chain_load_enable_out_n <= 1'b1;
		end
		else if (ce)
		begin
			io_hiz_n       <= (st_d == ST_USER) | (st_d == ST_INIT);
			weak_pullup_en <= (st_d != ST_USER) & ~pu_s_q[1];
			user_reset     <= (st_d != ST_USER);
			user_mode      <= (st_d == ST_USER);
			command_mode   <= (st_d != ST_USER);
			chain_load_enable_out_n <= ~((st_q == ST_INIT) | (st_q == ST_USER));
		end
	end
endmodule // cms_config_mode_sequencer

`default_nettype wire

// file: sim/cms_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "cms_defines.vh"
// ****
// Port checker
// ****
module cms_asserts (
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic       pullup_disable_sel,
	input wire logic       reconfig_request_n,
	input wire logic       chain_load_enable_in_n,
	input wire logic [2:0] load_scheme,
	input wire logic [9:0] tap_instr,
	input wire logic       tap_update,
	input wire logic       load_ready,
	input wire logic       frame_write,
	input wire logic       io_hiz_n,
	input wire logic       weak_pullup_en,
	input wire logic       user_mode,
	input wire logic       command_mode,
	input wire logic       chain_load_enable_out_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// Mode, pin and load relations
	mode_excl_a: assert property (user_mode != command_mode)
		else $error("user and command mode overlap");
	user_io_a: assert property (user_mode |-> io_hiz_n && !chain_load_enable_out_n)
		else $error("user mode with pins off or chain held");
	init_len_a: assert property ($rose(io_hiz_n) |-> !user_mode ##[15:18] $rose(user_mode))
		else $error("init phase length wrong");
	pin_reload_a: assert property
		($fell(reconfig_request_n) && user_mode |-> ##[1:6] command_mode && !io_hiz_n)
		else $error("pin request did not reload");
	tap_reload_a: assert property
		(tap_update && tap_instr == `CMS_IR_RECONFIG && user_mode |-> ##[1:3] command_mode)
		else $error("test port request did not reload");
	pullup_off_a: assert property
		((command_mode && pullup_disable_sel)[*5] |-> !weak_pullup_en)
		else $error("pull-ups on while disabled");
	pullup_on_a: assert property
		((command_mode && !pullup_disable_sel)[*5] |-> weak_pullup_en)
		else $error("pull-ups off while enabled");
	chain_wait_a: assert property (chain_load_enable_in_n[*3] |-> !load_ready)
		else $error("load taken while chain disabled");
	bad_scheme_a: assert property (load_scheme > 3'h4 |-> !load_ready)
		else $error("load taken on unknown scheme");
	frame_cmd_a: assert property (frame_write |-> command_mode)
		else $error("array write in user mode");
	// Main scenarios reached
	cover property ($rose(user_mode));
	cover property (frame_write);
	cover property ($fell(reconfig_request_n) && user_mode);
endmodule // cms_asserts
bind cms_config_mode_sequencer cms_asserts u_cms_asserts (
	.mclk                    (mclk),
	.rst_b                   (rst_b),
	.pullup_disable_sel      (pullup_disable_sel),
	.reconfig_request_n      (reconfig_request_n),
	.chain_load_enable_in_n  (chain_load_enable_in_n),
	.load_scheme             (load_scheme),
	.tap_instr               (tap_instr),
	.tap_update              (tap_update),
	.load_ready              (load_ready),
	.frame_write             (frame_write),
	.io_hiz_n                (io_hiz_n),
	.weak_pullup_en          (weak_pullup_en),
	.user_mode               (user_mode),
	.command_mode            (command_mode),
	.chain_load_enable_out_n (chain_load_enable_out_n)
);
`default_nettype wire

// file: sim/cms_cfg_source.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Configuration source and cipher model
// ****
module cms_cfg_source (
	input  wire logic       mclk,
	input  wire logic       load_ready,
	input  wire logic       aes_start,
	input  wire logic [7:0] aes_byte,
	output logic      [7:0] load_data,
	output logic            load_strobe,
	output logic            load_last,
	output logic            host_wr,
	output logic      [7:0] host_wdata,
	output logic            aes_done,
	output logic      [7:0] aes_plain
);
	logic [7:0] held;
	int         wait_n;
	// Quiet lines at time zero
	initial
	begin
		{load_strobe, load_last, host_wr, aes_done} = 4'h0;
		{load_data, host_wdata, aes_plain, held} = 32'h0;
		wait_n = 0;
	end
	// Holds a byte until the edge that takes it; no release so bytes may go back to back
	task automatic send(input logic [7:0] b, input logic l, input logic h, output logic ok);
		int n;
		n = 0;
		load_data <= b;
		host_wdata <= b;
		load_last <= l;
		load_strobe <= !h;
		host_wr <= h;
		@(negedge mclk);
		while (load_ready !== 1'b1 && n < 300)
		begin
			@(negedge mclk);
			n++;
		end
		@(posedge mclk);
		ok = n < 300;
	endtask
	// Released data lines show the inverse, not a stale copy
	task automatic idle;
		load_data <= ~load_data;
		host_wdata <= ~host_wdata;
		{load_strobe, load_last, host_wr} <= 3'h0;
	endtask
	// Cipher answers after a stall of 1 to 4 cycles; result only valid with done
	always @(posedge mclk)
	begin
		if (aes_start === 1'b1)
		begin
			held <= aes_byte ^ 8'hA5;
			wait_n <= 1 + aes_byte[1:0];
			aes_done <= 1'b0;
			aes_plain <= ~aes_plain;
		end
		else if (wait_n == 1)
		begin
			wait_n <= 0;
			aes_done <= 1'b1;
			aes_plain <= held;
		end
		else
		begin
			if (wait_n > 0)
				wait_n <= wait_n - 1;
			aes_done <= 1'b0;
			aes_plain <= ~aes_plain;
		end
	end
endmodule // cms_cfg_source
`default_nettype wire

// file: sim/cms_config_mode_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Sequencer regression
// ****
module cms_config_mode_sequencer_test;
	localparam int LONG_C = 20;
	localparam int SHORT_C = 10;
	logic mclk, rst_b, ce, power_on_delay_select, pullup_disable_sel, reconfig_request_n;
	logic chain_load_enable_in_n, decompress_en, decrypt_en, load_strobe, load_last, ok;
	logic tap_update, host_wr, load_ready, frame_write, aes_start, aes_done, io_hiz_n;
	logic weak_pullup_en, user_reset, user_mode, command_mode, chain_load_enable_out_n;
	logic [2:0]   load_scheme;
	logic [9:0]   tap_instr;
	logic [127:0] aes_key;
	logic [7:0]   load_data, host_wdata, frame_data, aes_byte, aes_plain;
	logic [31:0]  rs;
	logic [7:0]   expq[$];
	int           n_mismatch, compares;
	cms_config_mode_sequencer #(.POR_LONG_CYC(LONG_C[23:0]), .POR_SHORT_CYC(SHORT_C[23:0]))
		u_cms_config_mode_sequencer (.*);
	cms_cfg_source u_cms_cfg_source (.*);
	// 125 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Bounded wait for a mode
	task automatic wait_um(input logic w);
		int n;
		n = 0;
		while (user_mode !== w && n < 400)
		begin
			@(posedge mclk);
			n++;
		end
		if (n == 400)
		begin
			n_mismatch++;
			complete_run();
		end
	endtask
	// Power-up; select flips after capture to show it is ignored
	task automatic por(input logic s, input int exp_c);
		int n;
		n = 0;
		rst_b <= 1'b0;
		power_on_delay_select <= s;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		while (load_ready !== 1'b1 && n < 100)
		begin
			@(posedge mclk);
			n++;
			if (n == 3)
				power_on_delay_select <= !s;
		end
		check({7'h0, n >= exp_c && n <= exp_c + 6}, 8'h01);
		$display("power-up test done");
	endtask
	// Reload through the pin or the test port
	task automatic reconfig(input logic via_tap);
		tap_update <= via_tap;
		tap_instr <= 10'h001;
		reconfig_request_n <= via_tap;
		@(posedge mclk);
		tap_update <= 1'b0;
		repeat (3) @(posedge mclk);
		reconfig_request_n <= 1'b1;
		wait_um(1'b0);
		check({7'h0, io_hiz_n}, 8'h00);
		check({7'h0, user_reset}, 8'h01);
		$display("reload test done");
	endtask
	// Four units on one scheme: plain, run-length pairs or ciphered
	task automatic load_run(input logic [2:0] s, input logic [1:0] m);
		logic [7:0] b;
		logic       h;
		h = s == 3'h2 || s == 3'h3;
		rs = xs(rs);
		load_scheme <= s;
		{decrypt_en, decompress_en} <= m;
		pullup_disable_sel <= rs[9];
		@(posedge mclk);
		for (int i = 0; i < 4; i++)
		begin
			rs = xs(rs);
			b = rs[7:0];
			if (m == 2'h1)
			begin
				u_cms_cfg_source.send(8'(i + 1), 1'b0, h, ok);
				repeat (i + 1) expq.push_back(b);
			end
			else
				expq.push_back(m[1] ? b ^ 8'hA5 : b);
			u_cms_cfg_source.send(b, i == 3, h, ok);
			check({7'h0, ok}, 8'h01);
		end
		u_cms_cfg_source.idle();
		wait_um(1'b1);
		check({5'h0, user_reset, io_hiz_n, chain_load_enable_out_n}, 8'h02);
		check(8'(expq.size()), 8'h00);
		$display("load test done");
	endtask
	// Each array write takes the oldest expected byte
	always @(posedge mclk)
		if (frame_write === 1'b1)
			check(frame_data, expq.size() > 0 ? expq.pop_front() : 8'hXX);
	// Hang guard
	initial
	begin
		repeat (50000) @(posedge mclk);
		n_mismatch++;
		complete_run();
	end
	// Main sequence
	initial
	begin
		{ce, reconfig_request_n, chain_load_enable_in_n, pullup_disable_sel} = 4'hC;
		{decompress_en, decrypt_en, tap_update} = 3'h0;
		{load_scheme, tap_instr} = 13'h0;
		aes_key = {16{8'h5A}};
		rs = 32'h822ED124;
		{n_mismatch, compares} = 64'h0;
		por(1'b0, LONG_C);
		load_run(3'h0, 2'h0);
		for (int s = 1; s < 5; s++)
		begin
			reconfig(s[0]);
			load_run(3'(s), 2'h0);
		end
		reconfig(1'b0);
		load_run(3'h2, 2'h1);
		reconfig(1'b1);
		load_run(3'h0, 2'h2);
		reconfig(1'b0);
		chain_load_enable_in_n <= 1'b1;
		repeat (4) @(posedge mclk);
		check({7'h0, load_ready}, 8'h00);
		chain_load_enable_in_n <= 1'b0;
		load_scheme <= 3'h7;
		repeat (4) @(posedge mclk);
		check({7'h0, load_ready}, 8'h00);
		$display("refusal test done");
		load_run(3'h1, 2'h0);
		por(1'b1, SHORT_C);
		complete_run();
	end
endmodule // cms_config_mode_sequencer_test
`default_nettype wire
